// File: logic/card_socket_system_control.sv
// Overview of operation
// - Stream-busy bit sets at power request, clears after stream and delay.
// - Rise-settle bit holds after power-up stream until rise delay expires.
// - Fall-settle bit holds after power-down stream until fall delay expires.
// - Card-probe bit reads one while interrogation runs, resets to zero.
// - Bit 7 gates the legacy auto power-switch enable; resets to zero.
// - Bit 6 stops CardBus state machine clock when card idle, clock stopped.
// - Bit 5 locks ID registers read-only; zero makes them writable; default one.
// - Bit 4 forwards CardBus data parity errors onto system error.
// - Bit 2 picks legacy socket voltage: zero 3.3 V, one 5 V.
// - Bit 1 refuses clock stop on both clock-run protocols.
// - Bit 0 zero shares pin, ring wins; one routes only wake event.
// - Routing register resets to 0000_1000h, all terminals general inputs.
// - Routing default may be replaced by a serial EEPROM value at init.
`timescale 1ns/1ps
`default_nettype none
`include "card_socket_defines.svh"

module card_socket_system_control #(
    parameter int RISE_SETTLE_CYCLES = `RISE_SETTLE_US * `CLK_MHZ,
    parameter int FALL_SETTLE_CYCLES = `FALL_SETTLE_US * `CLK_MHZ
) (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // Configuration access
    input  wire card_socket_pkg::cfg_addr_t cfgAddr,
    input  wire logic                     cfgWrite,
    input  wire logic                     cfgRead,
    input  wire logic [3:0]               cfgByteEn,
    input  wire card_socket_pkg::dword_t  cfgWriteData,
    output card_socket_pkg::dword_t       cfgReadData,
    // Power and probe events
    input  wire logic                     powerRequest,
    input  wire logic                     powerUp,
    input  wire logic                     cardProbeActive,
    output logic                          switchData,
    output logic                          switchClockEn,
    // Serial EEPROM default load
    input  wire logic                     eepromLoad,
    input  wire card_socket_pkg::dword_t  eepromRouting,
    // Functional outputs
    input  wire logic                     legacyAutoSwitchBit,
    output logic                          autoSwitchEnable,
    input  wire logic                     cardbusCardIdle,
    input  wire logic                     cardbusClockStopped,
    output logic                          cardbusEngineClockEn,
    output logic                          idWriteEnable,
    input  wire logic                     cardbusParityError,
    output logic                          sysErrRequest,
    output logic                          legacyVoltage5v,
    input  wire logic                     clockStopRequest,
    output logic                          clockStopAllow,
    input  wire logic                     ringIndicate,
    input  wire logic                     ringEnable,
    input  wire logic                     wakeEvent,
    input  wire logic                     wakeEnable,
    output logic                          ringWakePin,
    output card_socket_pkg::dword_t       routing
);
    import card_socket_pkg::*;

    logic   [7:0] ctrlLow;
    logic   [7:0] next_ctrlLow;
    dword_t       next_routing;
    dword_t       next_cfgReadData;
    logic         probeBusy;
    logic         next_probeBusy;
    logic         streamBusy;
    logic         risePending;
    logic         fallPending;
    dword_t       sysctrlView;

    function automatic dword_t merge_bytes(input dword_t oldVal, input dword_t newVal,
                                           input logic [3:0] be);
        dword_t r;
        r = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    power_stream_sequencer #(
        .RISE_CYCLES (RISE_SETTLE_CYCLES),
        .FALL_CYCLES (FALL_SETTLE_CYCLES)
    ) u_seq (
        .clk           (clk),
        .reset_n       (reset_n),
        .powerRequest  (powerRequest),
        .powerUp       (powerUp),
        .streamBusy    (streamBusy),
        .risePending   (risePending),
        .fallPending   (fallPending),
        .switchData    (switchData),
        .switchClockEn (switchClockEn)
    );

    always_comb begin
        sysctrlView = `SYSCTRL_FIXED_ONES;
        sysctrlView[`BIT_STREAM_BUSY]  = streamBusy;
        sysctrlView[`BIT_RISE_PENDING] = risePending;
        sysctrlView[`BIT_FALL_PENDING] = fallPending;
        sysctrlView[`BIT_PROBE_BUSY]   = probeBusy;
        sysctrlView[7:0]               = ctrlLow;
    end

    always_comb begin
        next_ctrlLow     = ctrlLow;
        next_routing     = routing;
        next_probeBusy   = cardProbeActive;
        next_cfgReadData = cfgReadData;
        if (eepromLoad) begin
            next_routing = eepromRouting;
        end else if (cfgWrite && cfgAddr == `ROUTING_OFFSET) begin
            next_routing = merge_bytes(routing, cfgWriteData, cfgByteEn);
        end
        // Only the low byte is writable; status bits 11..8 ignore writes
        if (cfgWrite && cfgAddr == `SYSCTRL_OFFSET && cfgByteEn[0]) begin
            next_ctrlLow = cfgWriteData[7:0];
        end
        if (cfgRead) begin
            unique case (cfgAddr)
                `SYSCTRL_OFFSET: next_cfgReadData = sysctrlView;
                `ROUTING_OFFSET: next_cfgReadData = routing;
                default:         next_cfgReadData = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlLow     <= `SYSCTRL_LOW_RESET;
            routing     <= `ROUTING_RESET;
            probeBusy   <= 1'b0;
            cfgReadData <= 32'h0000_0000;
        end else begin
            ctrlLow     <= next_ctrlLow;
            routing     <= next_routing;
            probeBusy   <= next_probeBusy;
            cfgReadData <= next_cfgReadData;
        end
    end

    assign autoSwitchEnable = ctrlLow[`BIT_AUTO_GATE] & legacyAutoSwitchBit;
    assign cardbusEngineClockEn = !(ctrlLow[`BIT_IDLE_GATING] && cardbusCardIdle
                                    && cardbusClockStopped);
    assign idWriteEnable = !ctrlLow[`BIT_ID_LOCK];
    assign sysErrRequest = ctrlLow[`BIT_PARITY_SERR] & cardbusParityError;
    assign legacyVoltage5v = ctrlLow[`BIT_VOLT_SEL];
    assign clockStopAllow = clockStopRequest & !ctrlLow[`BIT_CLK_INHIBIT];

    // Shared ring/wake terminal: with bit 0 clear, ring wins when both are enabled
    always_comb begin
        if (ctrlLow[`BIT_RING_SEL]) begin
            ringWakePin = wakeEnable & wakeEvent;
        end else if (ringEnable) begin
            ringWakePin = ringIndicate;
        end else begin
            ringWakePin = wakeEnable & wakeEvent;
        end
    end
endmodule : card_socket_system_control
`default_nettype wire

// File: logic/card_socket_defines.svh
`ifndef CARD_SOCKET_DEFINES_SVH
`define CARD_SOCKET_DEFINES_SVH

// Configuration dword offsets
`define ROUTING_OFFSET      8'h8c
`define SYSCTRL_OFFSET      8'h80
`define ROUTING_RESET       32'h0000_1000

// System control bit positions
`define BIT_STREAM_BUSY     11
`define BIT_RISE_PENDING    10
`define BIT_FALL_PENDING    9
`define BIT_PROBE_BUSY      8
`define BIT_AUTO_GATE       7
`define BIT_IDLE_GATING     6
`define BIT_ID_LOCK         5
`define BIT_PARITY_SERR     4
`define BIT_RSVD3           3
`define BIT_VOLT_SEL        2
`define BIT_CLK_INHIBIT     1
`define BIT_RING_SEL        0

// Reset values of the writable low bits (bit 5 set, the rest clear)
`define SYSCTRL_LOW_RESET   8'h20
// Bit 12 of the upper half reads as one
`define SYSCTRL_FIXED_ONES  32'h0000_1000

// Settle delays
`define RISE_SETTLE_US      1000
`define FALL_SETTLE_US      1000
`define CLK_MHZ             100
`define STREAM_BITS         5'h10

`endif

// File: logic/card_socket_pkg.sv
package card_socket_pkg;
    typedef enum logic [1:0] {
        PW_IDLE,
        PW_STREAM,
        PW_SETTLE
    } power_state_e;

    typedef logic [31:0] dword_t;
    typedef logic [7:0]  cfg_addr_t;
endpackage : card_socket_pkg

// File: logic/power_stream_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "card_socket_defines.svh"

module power_stream_sequencer #(
    parameter int RISE_CYCLES = 100000,
    parameter int FALL_CYCLES = 100000
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic powerRequest,
    input  wire logic powerUp,
    output logic      streamBusy,
    output logic      risePending,
    output logic      fallPending,
    output logic      switchData,
    output logic      switchClockEn
);
    import card_socket_pkg::*;

    power_state_e state;
    power_state_e next_state;
    logic [4:0]   bitCount;
    logic [4:0]   next_bitCount;
    logic [31:0]  delayCount;
    logic [31:0]  next_delayCount;
    logic         upDir;
    logic         next_upDir;

    always_comb begin
        next_state      = state;
        next_bitCount   = bitCount;
        next_delayCount = delayCount;
        next_upDir      = upDir;
        unique case (state)
            PW_IDLE: begin
                if (powerRequest) begin
                    next_state    = PW_STREAM;
                    next_bitCount = `STREAM_BITS;
                    next_upDir    = powerUp;
                end
            end
            PW_STREAM: begin
                next_bitCount = bitCount - 5'h01;
                if (bitCount == 5'h01) begin
                    next_state      = PW_SETTLE;
                    next_delayCount = upDir ? RISE_CYCLES : FALL_CYCLES;
                end
            end
            PW_SETTLE: begin
                next_delayCount = delayCount - 32'h1;
                if (delayCount <= 32'h1) begin
                    next_state = PW_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state      <= PW_IDLE;
            bitCount   <= 5'h00;
            delayCount <= 32'h0;
            upDir      <= 1'b0;
        end else begin
            state      <= next_state;
            bitCount   <= next_bitCount;
            delayCount <= next_delayCount;
            upDir      <= next_upDir;
        end
    end

    // Busy covers the stream and its delay
    assign streamBusy    = (state != PW_IDLE);
    assign risePending   = (state == PW_SETTLE) && upDir;
    assign fallPending   = (state == PW_SETTLE) && !upDir;
    assign switchClockEn = (state == PW_STREAM);
    assign switchData    = (state == PW_STREAM) && upDir;
endmodule : power_stream_sequencer
`default_nettype wire

// File: tb/card_socket_system_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module card_socket_chk (
    input wire logic                       clk,
    input wire logic                       reset_n,
    input wire card_socket_pkg::cfg_addr_t cfgAddr,
    input wire logic                       cfgRead,
    input wire card_socket_pkg::dword_t    cfgReadData,
    input wire logic                       powerRequest,
    input wire logic                       switchClockEn,
    input wire logic                       eepromLoad,
    input wire card_socket_pkg::dword_t    eepromRouting,
    input wire logic                       legacyAutoSwitchBit,
    input wire logic                       autoSwitchEnable,
    input wire logic                       cardbusCardIdle,
    input wire logic                       cardbusClockStopped,
    input wire logic                       cardbusEngineClockEn,
    input wire logic                       cardbusParityError,
    input wire logic                       sysErrRequest,
    input wire logic                       clockStopRequest,
    input wire logic                       clockStopAllow,
    input wire card_socket_pkg::dword_t    routing
);
    import card_socket_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Sixteen stream cycles, then the switch clock stops
    sequence streamRun;
        switchClockEn[*8] ##1 switchClockEn[*8] ##1 !switchClockEn;
    endsequence
    stream_len_a: assert property ($rose(switchClockEn) |-> streamRun)
        else $error("power stream length wrong");
    stream_cause_a: assert property ($rose(switchClockEn) |-> $past(powerRequest))
        else $error("power stream without request");
    route_reset_a: assert property ($rose(reset_n) |-> routing == 32'h0000_1000)
        else $error("routing reset value wrong");
    route_load_a: assert property (eepromLoad |=> routing == $past(eepromRouting))
        else $error("routing load from serial memory lost");
    route_read_a: assert property (cfgRead && cfgAddr == 8'h8c |=> cfgReadData == $past(routing))
        else $error("routing read value wrong");
    auto_gate_a: assert property (autoSwitchEnable |-> legacyAutoSwitchBit)
        else $error("auto switch enable without legacy bit");
    idle_gate_a: assert property (!cardbusEngineClockEn |-> cardbusCardIdle && cardbusClockStopped)
        else $error("engine clock stopped while card busy");
    parity_serr_a: assert property (sysErrRequest |-> cardbusParityError)
        else $error("system error without parity error");
    clk_inhibit_a: assert property (clockStopAllow |-> clockStopRequest)
        else $error("clock stop allowed without request");
endmodule : card_socket_chk
bind card_socket_system_control card_socket_chk u_chk (.clk, .reset_n, .cfgAddr, .cfgRead,
    .cfgReadData, .powerRequest, .switchClockEn, .eepromLoad, .eepromRouting,
    .legacyAutoSwitchBit, .autoSwitchEnable, .cardbusCardIdle, .cardbusClockStopped,
    .cardbusEngineClockEn, .cardbusParityError, .sysErrRequest, .clockStopRequest,
    .clockStopAllow, .routing);
`default_nettype wire

// File: tb/card_socket_system_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module card_socket_system_control_test;
    import card_socket_pkg::*;
    logic       clk, reset_n, cfgWrite, cfgRead, powerRequest, powerUp, cardProbeActive;
    logic       eepromLoad, legacyAutoSwitchBit, cardbusCardIdle, cardbusClockStopped;
    logic       cardbusParityError, clockStopRequest, ringIndicate, ringEnable;
    logic       wakeEvent, wakeEnable, switchData, switchClockEn, autoSwitchEnable;
    logic       cardbusEngineClockEn, idWriteEnable, sysErrRequest, legacyVoltage5v;
    logic       clockStopAllow, ringWakePin;
    logic [3:0] cfgByteEn;
    logic [6:0] pins;
    cfg_addr_t  cfgAddr;
    dword_t     cfgWriteData, cfgReadData, eepromRouting, routing, rd;
    int         failCount = 0;
    int         testsRun = 0;
    int         cycles = 0;
    assign pins = {autoSwitchEnable, cardbusEngineClockEn, idWriteEnable, sysErrRequest,
                   legacyVoltage5v, clockStopAllow, ringWakePin};
    card_socket_system_control #(.RISE_SETTLE_CYCLES(8), .FALL_SETTLE_CYCLES(8)) u_dut (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failCount++;
            $display("[ERR] %0t run did not finish", $time);
            conclude();
        end
    end
    task automatic chk(input dword_t got, input dword_t exp);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cfgWr(input cfg_addr_t a, input dword_t d, input logic [3:0] be);
        cfgAddr = a;
        cfgWriteData = d;
        cfgByteEn = be;
        cfgWrite = 1'b1;
        @(negedge clk);
        cfgWrite = 1'b0;
        @(negedge clk);
    endtask : cfgWr
    task automatic cfgRd(input cfg_addr_t a);
        cfgAddr = a;
        cfgRead = 1'b1;
        @(negedge clk);
        cfgRead = 1'b0;
        rd = cfgReadData;
        @(negedge clk);
    endtask : cfgRd
    // Walks one power change through stream, settle and idle
    task automatic powerCheck(input logic up, input logic [3:0] settle);
        powerUp = up;
        powerRequest = 1'b1;
        @(negedge clk);
        powerRequest = 1'b0;
        cfgRd(8'h80);
        chk(rd[11:8], 4'h8);
        chk({switchClockEn, switchData}, {1'b1, up});
        repeat (17) @(negedge clk);
        cfgRd(8'h80);
        chk(rd[11:8], settle);
        repeat (10) @(negedge clk);
        cfgRd(8'h80);
        chk(rd[11:8], 4'h0);
        chk({switchClockEn, switchData}, 2'b00);
    endtask : powerCheck
    initial begin
        {reset_n, cfgWrite, cfgRead, powerRequest, powerUp, cardProbeActive, eepromLoad} = '0;
        {legacyAutoSwitchBit, cardbusCardIdle, cardbusClockStopped, cardbusParityError} = '0;
        {clockStopRequest, ringIndicate, ringEnable, wakeEvent, wakeEnable} = '0;
        {cfgByteEn, cfgAddr, cfgWriteData, eepromRouting} = '0;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        cfgRd(8'h80);
        chk(rd, 32'h0000_1020);
        cfgRd(8'h8c);
        chk(rd, 32'h0000_1000);
        $display("reset values test done");
        {legacyAutoSwitchBit, cardbusCardIdle, cardbusClockStopped, cardbusParityError} = 4'hf;
        {clockStopRequest, ringEnable, ringIndicate, wakeEnable} = 4'hf;
        cfgWr(8'h80, 32'hffff_fff7, 4'hf);
        cfgRd(8'h80);
        chk(rd, 32'h0000_10f7);
        chk(pins, 7'b1001100);
        {ringIndicate, wakeEvent} = 2'b01;
        cfgWr(8'h80, 32'h0, 4'hf);
        chk(pins, 7'b0110010);
        cfgWr(8'h80, 32'hff, 4'he);
        cfgRd(8'h80);
        chk(rd, 32'h0000_1000);
        $display("control bits test done");
        cardProbeActive = 1'b1;
        @(negedge clk);
        cfgRd(8'h80);
        chk(rd[11:8], 4'h1);
        cardProbeActive = 1'b0;
        @(negedge clk);
        cfgRd(8'h80);
        chk(rd[11:8], 4'h0);
        powerCheck(1'b1, 4'hc);
        powerCheck(1'b0, 4'ha);
        $display("status bits test done");
        cfgWr(8'h8c, 32'h1234_5678, 4'h5);
        chk(routing, 32'h0034_1078);
        eepromRouting = 32'h00ab_cdef;
        eepromLoad = 1'b1;
        cfgWr(8'h8c, 32'h0, 4'hf);
        eepromLoad = 1'b0;
        chk(routing, 32'h00ab_cdef);
        $display("routing test done");
        conclude();
    end
endmodule : card_socket_system_control_test
`default_nettype wire
